// File: design/afpg_top.sv
/*
 * AC line firing pattern generator: decides per line cycle or half cycle
 * whether the load switch conducts, for contactor, single-cycle, burst,
 * burst with start ramp, delayed-trigger burst and balanced half-cycle firing.
 * Assumes zc_pulse marks each line zero crossing for one clock and line_pos
 * gives the polarity of the half cycle that starts there.
 */
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "afpg_cfg.svh"
module afpg_top
    import afpg_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [`AFPG_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic zc_pulse,
    input wire logic line_pos,
    input wire logic enable_in,
    input wire logic ilimit_cut,
    output logic gate_out
);
    afpg_cfg_if cfg_bus();

    afpg_mode_t mode_ff;
    afpg_byte_t demand_ff;
    afpg_byte_t min_ff;
    afpg_byte_t ramp_ff;
    afpg_byte_t delay_ff;
    afpg_byte_t acc_ff;
    afpg_byte_t blk_ff;
    afpg_byte_t hc_idx_ff;
    logic run_ff;
    logic conduct_ff;
    logic phased_ff;
    afpg_byte_t angle_ff;
    logic [1:0] imb_ff;
    logic gate_ff;
    logic fire_ok;

    afpg_mode_t cfg_mode;
    afpg_byte_t cfg_demand;
    afpg_byte_t cfg_min;
    logic cyc_mode;
    logic boundary;
    afpg_mode_t eff_mode;
    afpg_byte_t eff_demand;
    afpg_byte_t eff_min;
    afpg_byte_t modulus;
    afpg_byte_t acc_sum;
    logic want;
    logic blocked;
    logic nxt_run;
    afpg_byte_t nxt_hc_idx;

    // Acc at most modulus and demand at most 100 keep the sum inside 8 bits
    function automatic afpg_byte_t ramp_angle(input afpg_byte_t idx, input afpg_byte_t len);
        logic [15:0] num;
        num = 16'(`AFPG_HALF_DEG) * 16'(len - idx);
        return 8'(num / (16'(len) + 16'h0001));
    endfunction

    function automatic logic is_cycle_mode(input afpg_mode_t m);
        return (m == AFPG_SINGLE) || (m == AFPG_BURST) || (m == AFPG_BURST_RAMP)
            || (m == AFPG_BURST_DELAY);
    endfunction

    afpg_regs u_regs (
        .clock(clock),
        .nrst(nrst),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .cfg(cfg_bus.regs)
    );

    afpg_phase_timer u_phase (
        .clock(clock),
        .nrst(nrst),
        .zc_pulse(zc_pulse),
        .phased(phased_ff),
        .angle(angle_ff),
        .fire_ok(fire_ok)
    );

    // Unknown selector codes fall back to contactor, which is the safe follower
    assign cfg_mode = (cfg_bus.mode > 3'(AFPG_HALF)) ? AFPG_CONTACTOR
                    : afpg_mode_t'(cfg_bus.mode);
    assign cfg_demand = (cfg_bus.demand > 7'(`AFPG_FULL_PCT)) ? `AFPG_FULL_PCT
                      : {1'b0, cfg_bus.demand};
    assign cfg_min = (cfg_mode == AFPG_SINGLE || cfg_bus.min_cyc == 8'h00) ? 8'h01
                   : cfg_bus.min_cyc;

    // A cycle pattern may only be left at the end of its block
    assign cyc_mode = is_cycle_mode(mode_ff);
    assign boundary = zc_pulse && (!cyc_mode || (line_pos && blk_ff == 8'h00));
    assign eff_mode = boundary ? cfg_mode : mode_ff;
    assign eff_demand = boundary ? cfg_demand : demand_ff;
    assign eff_min = boundary ? cfg_min : min_ff;

    // Half-cycle modulus stretches low demand to give one in three at 25%
    assign modulus = (eff_mode == AFPG_HALF && eff_demand < `AFPG_HALF_PCT)
                   ? eff_demand + `AFPG_HALF_PCT : `AFPG_FULL_PCT;
    assign acc_sum = acc_ff + eff_demand;
    assign want = acc_sum >= modulus;
    assign blocked = (imb_ff == 2'b01 && line_pos) || (imb_ff == 2'b11 && !line_pos);
    assign nxt_run = want;
    assign nxt_hc_idx = (nxt_run && !run_ff) ? 8'h00
                      : (hc_idx_ff == 8'hff) ? hc_idx_ff : hc_idx_ff + 8'h01;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_ff <= AFPG_CONTACTOR;
            demand_ff <= 8'h00;
            min_ff <= 8'h01;
            ramp_ff <= 8'h00;
            delay_ff <= 8'h00;
        end
        else if (boundary)
        begin
            mode_ff <= cfg_mode;
            demand_ff <= cfg_demand;
            min_ff <= cfg_min;
            ramp_ff <= cfg_bus.ramp_hc;
            delay_ff <= cfg_bus.delay_deg;
        end
    end

    // Block counter: a decision lasts min_ff whole cycles, on or off alike
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            blk_ff <= 8'h00;
        else if (zc_pulse && line_pos && is_cycle_mode(eff_mode))
        begin
            if (boundary)
                blk_ff <= eff_min - 8'h01;
            else
                blk_ff <= blk_ff - 8'h01;
        end
        else if (boundary)
            blk_ff <= 8'h00;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            acc_ff <= 8'h00;
            run_ff <= 1'b0;
            hc_idx_ff <= 8'h00;
        end
        else if (zc_pulse)
        begin
            case (eff_mode)
                AFPG_SINGLE, AFPG_BURST, AFPG_BURST_RAMP, AFPG_BURST_DELAY:
                begin
                    if (boundary)
                    begin
                        acc_ff <= want ? acc_sum - modulus : acc_sum;
                        run_ff <= nxt_run;
                        hc_idx_ff <= nxt_hc_idx;
                    end
                    else if (hc_idx_ff != 8'hff)
                        hc_idx_ff <= hc_idx_ff + 8'h01;
                end
                AFPG_HALF:
                begin
                    // A deferred half keeps one firing of credit, so the sum stays in 8 bits
                    if (!want)
                        acc_ff <= acc_sum;
                    else if (blocked)
                        acc_ff <= modulus;
                    else
                        acc_ff <= acc_sum - modulus;
                    run_ff <= want && !blocked;
                    hc_idx_ff <= 8'h00;
                end
                default:
                begin
                    acc_ff <= 8'h00;
                    run_ff <= enable_in;
                    hc_idx_ff <= 8'h00;
                end
            endcase
        end
    end

    // Net polarity of conducted halves, held within one half cycle either way
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            imb_ff <= 2'b00;
        else if (zc_pulse && eff_mode == AFPG_HALF && want && !blocked)
            imb_ff <= line_pos ? imb_ff + 2'b01 : imb_ff - 2'b01;
        else if (boundary && eff_mode != AFPG_HALF)
            imb_ff <= 2'b00;
    end

    // Conduction and firing angle change only at a zero crossing
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            conduct_ff <= 1'b0;
            phased_ff <= 1'b0;
            angle_ff <= 8'h00;
        end
        else if (zc_pulse)
        begin
            phased_ff <= 1'b0;
            angle_ff <= 8'h00;
            case (eff_mode)
                AFPG_CONTACTOR:
                    conduct_ff <= enable_in;
                AFPG_HALF:
                    conduct_ff <= want && !blocked;
                AFPG_BURST_RAMP:
                begin
                    conduct_ff <= boundary ? nxt_run : run_ff;
                    if ((boundary ? nxt_hc_idx : hc_idx_ff + 8'h01) < ramp_ff)
                    begin
                        phased_ff <= 1'b1;
                        angle_ff <= ramp_angle(boundary ? nxt_hc_idx : hc_idx_ff + 8'h01,
                                               ramp_ff);
                    end
                end
                AFPG_BURST_DELAY:
                begin
                    conduct_ff <= boundary ? nxt_run : run_ff;
                    if (boundary && nxt_run && !run_ff)
                    begin
                        phased_ff <= 1'b1;
                        angle_ff <= cfg_bus.delay_deg;
                    end
                end
                AFPG_SINGLE, AFPG_BURST:
                    conduct_ff <= boundary ? nxt_run : run_ff;
                default:
                    conduct_ff <= 1'b0;
            endcase
        end
    end

    // Once fired, the switch stays on to the next crossing; limit may cut it
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            gate_ff <= 1'b0;
        else
            gate_ff <= conduct_ff && fire_ok && !ilimit_cut;
    end

    assign gate_out = gate_ff;
    assign cfg_bus.st_gate = gate_ff;
    assign cfg_bus.st_run = conduct_ff;
    assign cfg_bus.st_mode = mode_ff;
    assign cfg_bus.st_acc = acc_ff;
endmodule // afpg_top

// File: design/afpg_cfg.svh
/*
 * Constants of the ac line firing pattern generator: register offsets,
 * field positions, reset values and pattern arithmetic constants.
 * Assumes inclusion by bare name from the package and design modules.
 */
`ifndef AFPG_CFG_SVH
`define AFPG_CFG_SVH

`define AFPG_ADDR_W 5
`define AFPG_OFF_MODE 5'h00
`define AFPG_OFF_DEMAND 5'h04
`define AFPG_OFF_MINCYC 5'h08
`define AFPG_OFF_RAMP 5'h0c
`define AFPG_OFF_DELAY 5'h10
`define AFPG_OFF_STATUS 5'h14

`define AFPG_RST_MODE 3'h0
`define AFPG_RST_DEMAND 7'h00
`define AFPG_RST_MINCYC 8'h04
`define AFPG_RST_RAMP 8'h06
`define AFPG_RST_DELAY 8'h50

`define AFPG_ST_GATE 0
`define AFPG_ST_RUN 1
`define AFPG_ST_MODE_LO 2
`define AFPG_ST_MODE_HI 4
`define AFPG_ST_ACC_LO 8
`define AFPG_ST_ACC_HI 15

`define AFPG_FULL_PCT 8'h64
`define AFPG_HALF_PCT 8'h32
`define AFPG_HALF_DEG 8'hb4
`define AFPG_PER_W 20
`define AFPG_PER_MAX 20'hfffff

`endif

// File: design/afpg_pkg.sv
/*
 * Types shared by the firing pattern generator modules.
 * Assumes afpg_cfg.svh on the include path.
 */
package afpg_pkg;
`include "afpg_cfg.svh"

    typedef enum logic [2:0] {
        AFPG_CONTACTOR,
        AFPG_SINGLE,
        AFPG_BURST,
        AFPG_BURST_RAMP,
        AFPG_BURST_DELAY,
        AFPG_HALF
    } afpg_mode_t;

    typedef logic [7:0] afpg_byte_t;
endpackage

// File: design/afpg_cfg_if.sv
/*
 * Carrier between the register slave and the pattern core: settings
 * toward the core, live state back for the status register.
 * Assumes both ends are clocked by the same clock.
 */
`timescale 1ns/1ps
interface afpg_cfg_if;
    import afpg_pkg::*;
    logic [2:0] mode;
    logic [6:0] demand;
    afpg_byte_t min_cyc;
    afpg_byte_t ramp_hc;
    afpg_byte_t delay_deg;
    logic st_gate;
    logic st_run;
    logic [2:0] st_mode;
    afpg_byte_t st_acc;

    modport regs (output mode, demand, min_cyc, ramp_hc, delay_deg,
                  input st_gate, st_run, st_mode, st_acc);
    modport core (input mode, demand, min_cyc, ramp_hc, delay_deg,
                  output st_gate, st_run, st_mode, st_acc);
endinterface

// File: design/afpg_regs.sv
/*
 * Avalon-MM slave holding the pattern settings and the status word.
 * Assumes a master that holds its request until waitrequest is low.
 */
`timescale 1ns/1ps
`include "afpg_cfg.svh"
module afpg_regs
    import afpg_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [`AFPG_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    afpg_cfg_if.regs cfg
);
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [2:0] mode_ff;
    logic [6:0] demand_ff;
    afpg_byte_t mincyc_ff;
    afpg_byte_t ramp_ff;
    afpg_byte_t delay_ff;
    logic [31:0] nxt_rdata;
    logic req;

    // One wait state: read data is captured at the first edge, a write lands at the second
    assign req = (read | write) & ~ack_ff;
    assign waitrequest = (read | write) & ~ack_ff;
    assign readdata = rdata_ff;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            ack_ff <= 1'b0;
        else
            ack_ff <= req;
    end

    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        case (address)
            `AFPG_OFF_MODE: nxt_rdata[2:0] = mode_ff;
            `AFPG_OFF_DEMAND: nxt_rdata[6:0] = demand_ff;
            `AFPG_OFF_MINCYC: nxt_rdata[7:0] = mincyc_ff;
            `AFPG_OFF_RAMP: nxt_rdata[7:0] = ramp_ff;
            `AFPG_OFF_DELAY: nxt_rdata[7:0] = delay_ff;
            `AFPG_OFF_STATUS:
            begin
                nxt_rdata[`AFPG_ST_GATE] = cfg.st_gate;
                nxt_rdata[`AFPG_ST_RUN] = cfg.st_run;
                nxt_rdata[`AFPG_ST_MODE_HI:`AFPG_ST_MODE_LO] = cfg.st_mode;
                nxt_rdata[`AFPG_ST_ACC_HI:`AFPG_ST_ACC_LO] = cfg.st_acc;
            end
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rdata_ff <= 32'h0000_0000;
        else if (req && read)
            rdata_ff <= nxt_rdata;
    end

    // Settings are only shadows here; the core adopts them at its own boundaries
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_ff <= `AFPG_RST_MODE;
            demand_ff <= `AFPG_RST_DEMAND;
            mincyc_ff <= `AFPG_RST_MINCYC;
            ramp_ff <= `AFPG_RST_RAMP;
            delay_ff <= `AFPG_RST_DELAY;
        end
        else if (write && ack_ff)
        begin
            case (address)
                `AFPG_OFF_MODE: mode_ff <= writedata[2:0];
                `AFPG_OFF_DEMAND: demand_ff <= writedata[6:0];
                `AFPG_OFF_MINCYC: mincyc_ff <= writedata[7:0];
                `AFPG_OFF_RAMP: ramp_ff <= writedata[7:0];
                `AFPG_OFF_DELAY: delay_ff <= writedata[7:0];
                default: ;
            endcase
        end
    end

    assign cfg.mode = mode_ff;
    assign cfg.demand = demand_ff;
    assign cfg.min_cyc = mincyc_ff;
    assign cfg.ramp_hc = ramp_ff;
    assign cfg.delay_deg = delay_ff;
endmodule // afpg_regs

// File: design/afpg_phase_timer.sv
/*
 * Half-cycle period meter and phase-angle gate: measures the time between
 * zero crossings and releases the gate once the requested angle has passed.
 * Assumes zc_pulse is a one-cycle pulse synchronous to clock.
 */
`timescale 1ns/1ps
`include "afpg_cfg.svh"
module afpg_phase_timer
    import afpg_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic zc_pulse,
    input wire logic phased,
    input wire afpg_byte_t angle,
    output logic fire_ok
);
    logic [`AFPG_PER_W-1:0] cnt_ff;
    logic [`AFPG_PER_W-1:0] period_ff;
    logic [`AFPG_PER_W-1:0] thr;
    logic [`AFPG_PER_W+7:0] prod;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            cnt_ff <= '0;
        else if (zc_pulse)
            cnt_ff <= '0;
        else if (cnt_ff != `AFPG_PER_MAX)
            cnt_ff <= cnt_ff + 1'b1;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            period_ff <= '0;
        else if (zc_pulse)
            period_ff <= cnt_ff;
    end

    // Angles past 180 degrees clamp to the end of the half cycle
    assign prod = period_ff * ((angle > `AFPG_HALF_DEG) ? `AFPG_HALF_DEG : angle);
    assign thr = `AFPG_PER_W'(prod / `AFPG_HALF_DEG);
    assign fire_ok = !phased || (cnt_ff >= thr);
endmodule // afpg_phase_timer

// File: verification/afpg_top_checker.sv
/*
 * Port assertions for the firing pattern generator.
 * Assumes binding to afpg_top, one clock and an active low async reset.
 */
`timescale 1ns/1ps
`include "afpg_cfg.svh"
module afpg_top_checker
    import afpg_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [`AFPG_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic zc_pulse,
    input wire logic line_pos,
    input wire logic enable_in,
    input wire logic ilimit_cut,
    input wire logic gate_out
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    wait_rd_a: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
        else $error("read not answered after one wait state");
    wait_wr_a: assert property ($rose(write) |-> waitrequest ##1 !waitrequest)
        else $error("write not answered after one wait state");
    idle_nowait_a: assert property (!read && !write |-> !waitrequest)
        else $error("waitrequest high while idle");
    upper_zero_a: assert property (read && !waitrequest |-> readdata[31:16] == 16'h0)
        else $error("read data upper half not zero");
    unmapped_zero_a: assert property (read && !waitrequest
        && address > `AFPG_OFF_STATUS |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    read_hold_a: assert property (!read && !$past(read) |-> $stable(readdata))
        else $error("read data changed without a read");
    fall_at_zc_a: assert property ($fell(gate_out) |-> $past(zc_pulse, 2) || $past(ilimit_cut))
        else $error("gate dropped away from a zero crossing");
    rise_timing_a: assert property ($rose(gate_out) |-> !$past(zc_pulse) && !$past(ilimit_cut))
        else $error("gate rose too early or while cut");
    cut_next_a: assert property (ilimit_cut |=> !gate_out)
        else $error("gate not cut after current limit");
endmodule // afpg_top_checker

bind afpg_top afpg_top_checker u_chk (.clock(clock), .nrst(nrst), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .zc_pulse(zc_pulse), .line_pos(line_pos),
    .enable_in(enable_in), .ilimit_cut(ilimit_cut), .gate_out(gate_out));

// File: verification/afpg_line_model.sv
/*
 * Line and load switch model: alternating zero crossings, and per half
 * cycle a report of the switch drive early and late in that half.
 * Assumes one clock shared with the generator.
 */
`timescale 1ns/1ps
module afpg_line_model #(
    parameter int HALF_CLK = 50
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic gate_out,
    output logic zc_pulse,
    output logic line_pos,
    output logic half_done,
    output logic half_full,
    output logic half_late,
    output logic half_pos
);
    int cnt_ff;
    logic pos_ff;
    logic full_ff;
    logic late_ff;

    // Crossings alternate in polarity and stay a half period apart
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_ff <= 1;
            pos_ff <= 1'b0;
        end
        else if (cnt_ff == HALF_CLK - 1)
        begin
            cnt_ff <= 0;
            pos_ff <= !pos_ff;
        end
        else
            cnt_ff <= cnt_ff + 1;
    end

    // With HALF_CLK 50, early sample misses a half phase-fired past 14 degrees, late sample catches it up to 168
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            full_ff <= 1'b0;
            late_ff <= 1'b0;
        end
        else
        begin
            if (cnt_ff == 5)
                full_ff <= gate_out;
            if (cnt_ff == HALF_CLK - 3)
                late_ff <= gate_out;
        end
    end

    assign zc_pulse = (cnt_ff == 0);
    // Polarity is only meaningful with the pulse, so it wanders otherwise
    assign line_pos = zc_pulse ? pos_ff : cnt_ff[0];
    assign half_done = zc_pulse;
    assign half_full = full_ff;
    assign half_late = late_ff;
    assign half_pos = !pos_ff;
endmodule // afpg_line_model

// File: verification/test_ac_line_firing_pattern_gen.sv
/*
 * Self-checking bench for the firing pattern generator: registers over
 * Avalon-MM, patterns counted per half cycle from the line model.
 * Assumes design files, checker and line model compiled first.
 */
`timescale 1ns/1ps
`include "afpg_cfg.svh"
module test_ac_line_firing_pattern_gen
    import afpg_pkg::*;
;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic enable_in = 1'b0;
    logic ilimit_cut = 1'b0;
    logic [31:0] readdata;
    logic waitrequest, zc_pulse, line_pos, gate_out;
    logic half_done, half_full, half_late, half_pos;
    int miscompares = 0;
    int total_checks = 0;
    int seed = 82384;
    int meas_left = 0;
    int start_n = 0;
    int cf, cl, cp;
    bit arm = 1'b0;
    logic [31:0] q[$];
    logic [4:0] ua;

    always #25 clock = ~clock;

    afpg_top dut (.clock(clock), .nrst(nrst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .zc_pulse(zc_pulse), .line_pos(line_pos),
        .enable_in(enable_in), .ilimit_cut(ilimit_cut), .gate_out(gate_out));

    afpg_line_model #(.HALF_CLK(50)) u_line (.clock(clock), .nrst(nrst),
        .gate_out(gate_out), .zc_pulse(zc_pulse), .line_pos(line_pos),
        .half_done(half_done), .half_full(half_full), .half_late(half_late),
        .half_pos(half_pos));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        total_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    end
    endtask

    task automatic end_sim;
    begin
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask

    // Request stands until the rising edge that samples waitrequest low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    begin
        @(posedge clock);
        address <= a;
        read <= !w;
        write <= w;
        writedata <= d;
        @(posedge clock);
        while (waitrequest !== 1'b0)
            @(posedge clock);
        read <= 1'b0;
        write <= 1'b0;
    end
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    begin
        q.push_back(exp);
        bus(1'b0, a, 32'h0);
    end
    endtask

    // Window of n halves from a positive crossing: full, late, positive full
    task automatic meas(input int n, input int ef, input int el, input int ep);
    begin
        q.push_back(32'(ef));
        q.push_back(32'(el));
        q.push_back(32'(ep));
        start_n = n;
        arm = 1'b1;
        @(negedge clock);
        while (arm || meas_left > 0)
            @(negedge clock);
    end
    endtask

    task automatic settle(input int n);
    begin
        repeat (n) @(posedge clock iff zc_pulse);
    end
    endtask

    always @(negedge clock)
    begin
        if (half_done && meas_left > 0)
        begin
            cf = cf + int'(half_full);
            cl = cl + int'(half_late);
            cp = cp + int'(half_full & half_pos);
            meas_left--;
            if (meas_left == 0)
            begin
                chk(32'(cf), q.pop_front());
                chk(32'(cl), q.pop_front());
                chk(32'(cp), q.pop_front());
            end
        end
        if (arm && zc_pulse && line_pos)
        begin
            meas_left = start_n;
            arm = 1'b0;
            cf = 0;
            cl = 0;
            cp = 0;
        end
    end

    // Read data is taken at the edge that samples waitrequest low
    always @(posedge clock)
    begin
        if (read && waitrequest === 1'b0)
            chk(readdata, q.pop_front());
    end

    initial
    begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        rd(`AFPG_OFF_MODE, 32'h0);
        rd(`AFPG_OFF_DEMAND, 32'h0);
        rd(`AFPG_OFF_MINCYC, 32'h4);
        rd(`AFPG_OFF_RAMP, 32'h6);
        rd(`AFPG_OFF_DELAY, 32'h50);
        ua = 5'h18 | 5'($random(seed) & 7);
        bus(1'b1, ua, $random(seed));
        rd(ua, 32'h0);
        enable_in <= 1'b1;
        settle(4);
        meas(8, 8, 8, 4);
        @(posedge clock);
        ilimit_cut <= 1'b1;
        @(posedge clock);
        ilimit_cut <= 1'b0;
        settle(2);
        fork
            meas(2, 1, 1, 1);
            begin
                @(negedge clock iff (zc_pulse && line_pos));
                repeat (10 + ($random(seed) & 31)) @(posedge clock);
                enable_in <= 1'b0;
            end
        join
        meas(8, 0, 0, 0);
        bus(1'b1, `AFPG_OFF_MODE, 32'(AFPG_SINGLE));
        for (int i = 1; i <= 4; i++)
        begin
            bus(1'b1, `AFPG_OFF_DEMAND, 32'(25 * i));
            settle(16);
            meas(32, 8 * i, 8 * i, 4 * i);
        end
        bus(1'b1, `AFPG_OFF_MODE, 32'(AFPG_BURST));
        for (int i = 1; i <= 4; i++)
        begin
            bus(1'b1, `AFPG_OFF_DEMAND, 32'(25 * i));
            settle(32);
            meas(64, 16 * i, 16 * i, 8 * i);
        end
        bus(1'b1, `AFPG_OFF_MODE, 32'(AFPG_BURST_RAMP));
        bus(1'b1, `AFPG_OFF_DEMAND, 32'h19);
        settle(32);
        meas(64, 4, 16, 2);
        bus(1'b1, `AFPG_OFF_DEMAND, 32'h4b);
        settle(32);
        meas(64, 36, 48, 18);
        bus(1'b1, `AFPG_OFF_MODE, 32'(AFPG_BURST_DELAY));
        bus(1'b1, `AFPG_OFF_MINCYC, 32'h2);
        bus(1'b1, `AFPG_OFF_DELAY, 32'h32);
        bus(1'b1, `AFPG_OFF_DEMAND, 32'h19);
        settle(32);
        meas(64, 12, 16, 4);
        bus(1'b1, `AFPG_OFF_MODE, 32'(AFPG_HALF));
        settle(24);
        meas(48, 16, 16, 8);
        bus(1'b1, `AFPG_OFF_DEMAND, 32'h32);
        settle(24);
        meas(48, 24, 24, 12);
        end_sim();
    end

    initial
    begin
        #(100000 * 50);
        miscompares++;
        end_sim();
    end
endmodule // test_ac_line_firing_pattern_gen
